// [include/char_disp_pkg.sv]
package char_disp_pkg;
	// command bytes
	localparam logic [7:0] SET_POSITION_CMD = 8'h10;
	localparam logic [7:0] UNDERLINE_OFF_CMD = 8'h14;
	localparam logic [7:0] UNDERLINE_ON_CMD = 8'h15;
	localparam logic [7:0] UNDERLINE_BLINK_CMD = 8'h16;
	localparam logic [7:0] DOT_MARKER_MODE_CMD = 8'h17;
	localparam logic [7:0] RESET_CMD = 8'h1f;
	// dot marker mode bytes
	localparam logic [7:0] DOT_LIGHT = 8'hff;
	localparam logic [7:0] DOT_BLINK = 8'h88;
	localparam logic [7:0] DOT_NONE = 8'h00;
	// positions and characters
	localparam int NUM_DIGITS = 40;
	localparam logic [5:0] POS_HOME = 6'h00;
	localparam logic [5:0] POS_LAST = 6'h27;
	localparam logic [7:0] POS_LAST_B = 8'h27;
	localparam logic [7:0] SPACE_CHAR = 8'h20;
	localparam logic [7:0] BRIGHT_FULL = 8'hff;
	// self-test sequence bounds
	localparam logic [7:0] ST_DIGIT_FIRST = 8'h30;
	localparam logic [7:0] ST_DIGIT_LAST = 8'h39;
	localparam logic [7:0] ST_ALPHA_FIRST = 8'h41;
	localparam logic [7:0] ST_ALPHA_LAST = 8'h5a;
	localparam logic [7:0] ST_SYM_FIRST = 8'h21;
	localparam logic [7:0] ST_SYM_LAST = 8'h2f;
	// underline modes
	localparam logic [1:0] UL_OFF = 2'h0;
	localparam logic [1:0] UL_ON = 2'h1;
	localparam logic [1:0] UL_BLINK = 2'h2;
	// timing
	localparam int CLK_HZ_DEF = 100_000_000;
	localparam int CLK_NS = 10;
	localparam int BLINK_MS = 300;
	localparam int BLINK_CYC_DEF = CLK_HZ_DEF / 1000 * BLINK_MS;
	localparam int BUSY_WAIT_MIN_NS = 2000;
	localparam int BUSY_WAIT_CYC = (BUSY_WAIT_MIN_NS + CLK_NS - 1) / CLK_NS;
	localparam int WR_PW_NS = 50;
	localparam int WR_PW_CYC = (WR_PW_NS + CLK_NS - 1) / CLK_NS;
	localparam int WR_DELAY_NS = 150;
	localparam int WR_AFTER_CYC = (WR_DELAY_NS + CLK_NS - 1) / CLK_NS + 1;
	localparam int DIV_W = 18;
	// host registers, byte addresses
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_TXDATA = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h8;
	localparam int CTRL_SERIAL_BIT = 0;
	localparam int CTRL_TEST_BIT = 1;
	localparam int CTRL_STRAP_LSB = 2;
	localparam logic [4:0] CTRL_RESET = 5'h1d; // serial, all straps open
	localparam int STAT_ACTIVE_BIT = 0;
	localparam int STAT_BUSY_BIT = 1;

	// bit period in clocks; a strap reads 0 when shorted
	function automatic logic [DIV_W-1:0] baud_div(input logic sa,
		input logic sb, input logic sc, input int clk_hz);
		longint tenths;
		tenths = 64'd96000;
		unique case ({sc, sb, sa})
			3'b111: tenths = 64'd96000;
			3'b110: tenths = 64'd48000;
			3'b101: tenths = 64'd24000;
			3'b100: tenths = 64'd12000;
			3'b011: tenths = 64'd625000;
			3'b010: tenths = 64'd312500;
			3'b001: tenths = 64'd156250;
			3'b000: tenths = 64'd78125;
		endcase
		return DIV_W'((longint'(clk_hz) * 10 + tenths / 2) / tenths);
	endfunction
endpackage

// [include/char_link_if.sv]
`timescale 1ns/1ps
interface char_link_if;
	logic       test_n;
	logic       sel_n;
	logic       wr_n;
	logic [7:0] pdata;
	logic       rxd;
	logic       busy;
	logic       baud_strap_a;
	logic       baud_strap_b;
	logic       baud_strap_c;

	modport dev (input test_n, sel_n, wr_n, pdata, rxd,
		baud_strap_a, baud_strap_b, baud_strap_c, output busy);
	modport host (output test_n, sel_n, wr_n, pdata, rxd,
		baud_strap_a, baud_strap_b, baud_strap_c, input busy);
endinterface

// [design/char_disp_dev.sv]
// Summary of operation
// - position byte after 0x10 sets write position
// - underline off command hides underline
// - underline on command shows steady underline
// - underline blink command; blink at power-up
// - dot mode byte: ff light, 88 blink, 00 none
// - dot marker drawn at write position, overwrites
// - lighting mode hides occupied character
// - blink mode toggles each 0.3 s
// - no dot marker; selected at power-up
// - reset command erases all, homes position
// - reset leaves blink, no dot, full brightness
// - power-on clears memory like reset command
// - self-test low shows sequence on all digits
// - self-test ignores writes until test high
// - three straps select eight baud rates
// - all straps open gives 9600 baud
// - busy rises mid stop bit
// - busy wait lasts 2 to 45 us; code waits a fixed 200 clocks, which is 2 us only at 100 MHz
// - host picks mode, leaves unused lines open
// - decode the six command bytes
// - host writes only while busy low
// - parallel byte taken on write strobe rise
//
// The register addresses and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module char_disp_dev
	import char_disp_pkg::*;
#(
	parameter int CLK_HZ       = CLK_HZ_DEF,
	parameter int BLINK_CYCLES = BLINK_CYC_DEF
) (
	// clock and reset
	input  wire logic       REF_CLK,
	input  wire logic       RST,
	// link to host
	char_link_if.dev        LINK,
	// display side
	input  wire logic [5:0] RD_ADDR,
	output logic      [7:0] RD_DATA,
	output logic      [5:0] POS,
	output logic            UL_SHOW,
	output logic            DOT_SHOW,
	output logic            CHAR_SHOW,
	output logic      [7:0] BRIGHT,
	output logic            SELFTEST,
	output logic      [7:0] TEST_CHAR
);
	initial begin
		// fastest rate needs two clocks a bit; slowest must fit the divider
		if (CLK_HZ < 125_000 || CLK_HZ > 300_000_000 ||
			BLINK_CYCLES < 2)
			$error("char_disp_dev: parameters out of range");
	end

	typedef enum logic [3:0] {
		RX_IDLE = 4'b0001, RX_START = 4'b0010,
		RX_BITS = 4'b0100, RX_STOP = 4'b1000
	} rx_t;
	typedef enum logic [3:0] {
		IP_IDLE = 4'b0001, IP_POS = 4'b0010,
		IP_DOT = 4'b0100, IP_CLEAR = 4'b1000
	} ip_t;

	logic [7:0] mem [NUM_DIGITS];

	////////////////////////////////////////////////////////////////////////
	// receive: serial 8N1 and parallel strobe
	rx_t             rx_ff, nxt_rx;
	logic [DIV_W-1:0] cnt_ff, nxt_cnt;
	logic [2:0]      bit_ff, nxt_bit;
	logic [7:0]      sh_ff, nxt_sh;
	logic            wr_prev_ff;
	logic [DIV_W-1:0] div;
	logic            ser_vld, par_vld, byte_vld;
	logic [7:0]      byte_val;

	// straps read at every count reload, so a change takes effect at the next bit, even mid frame
	assign div = baud_div(LINK.baud_strap_a, LINK.baud_strap_b,
		LINK.baud_strap_c, CLK_HZ);

	// start verified at half bit, data sampled mid bit
	always_comb begin
		nxt_rx = rx_ff;
		nxt_cnt = cnt_ff;
		nxt_bit = bit_ff;
		nxt_sh = sh_ff;
		ser_vld = 1'b0;
		unique case (rx_ff)
			RX_IDLE: begin
				if (!LINK.rxd) begin
					nxt_rx = RX_START;
					nxt_cnt = div >> 1;
				end
			end
			RX_START: begin
				if (cnt_ff != '0) begin
					nxt_cnt = cnt_ff - 1'b1;
				end else if (!LINK.rxd) begin
					nxt_rx = RX_BITS;
					nxt_cnt = div - 1'b1;
					nxt_bit = 3'h0;
				end else begin
					nxt_rx = RX_IDLE; // glitch, not a start bit
				end
			end
			RX_BITS: begin
				if (cnt_ff != '0) begin
					nxt_cnt = cnt_ff - 1'b1;
				end else begin
					nxt_sh = {LINK.rxd, sh_ff[7:1]}; // lsb first
					nxt_cnt = div - 1'b1;
					nxt_bit = bit_ff + 1'b1;
					if (bit_ff == 3'h7)
						nxt_rx = RX_STOP;
				end
			end
			RX_STOP: begin
				if (cnt_ff != '0) begin
					nxt_cnt = cnt_ff - 1'b1;
				end else begin
					ser_vld = LINK.rxd; // framing error drops byte
					nxt_rx = RX_IDLE;
				end
			end
		endcase
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			rx_ff <= RX_IDLE;
			cnt_ff <= '0;
			bit_ff <= 3'h0;
			sh_ff <= 8'h00;
			wr_prev_ff <= 1'b1;
		end else begin
			rx_ff <= nxt_rx;
			cnt_ff <= nxt_cnt;
			bit_ff <= nxt_bit;
			sh_ff <= nxt_sh;
			wr_prev_ff <= LINK.wr_n;
		end
	end

	// strobe rise with select low
	assign par_vld = !wr_prev_ff && LINK.wr_n && !LINK.sel_n;
	assign byte_val = par_vld ? LINK.pdata : sh_ff;

	////////////////////////////////////////////////////////////////////////
	// interpreter, busy and character memory
	ip_t        ip_ff, nxt_ip;
	logic [5:0] pos_ff, nxt_pos, clr_ff, nxt_clr;
	logic [1:0] ul_ff, nxt_ul;
	logic [7:0] dot_ff, nxt_dot;
	logic       busy_ff, nxt_busy;
	logic [7:0] wait_ff, nxt_wait;
	logic       mem_we;
	logic [5:0] mem_addr;
	logic [7:0] mem_wd;

	// self-test and a busy device refuse bytes
	assign byte_vld = (par_vld || ser_vld) && LINK.test_n && !busy_ff;

	always_comb begin
		nxt_ip = ip_ff;
		nxt_pos = pos_ff;
		nxt_clr = clr_ff;
		nxt_ul = ul_ff;
		nxt_dot = dot_ff;
		nxt_busy = busy_ff;
		nxt_wait = wait_ff;
		mem_we = 1'b0;
		mem_addr = pos_ff;
		mem_wd = byte_val;
		// busy wait runs out only after any erase is done
		if (byte_vld) begin
			nxt_busy = 1'b1;
			nxt_wait = 8'(BUSY_WAIT_CYC);
		end else if (busy_ff && ip_ff != IP_CLEAR) begin
			nxt_wait = wait_ff - 1'b1;
			if (wait_ff == 8'h01)
				nxt_busy = 1'b0;
		end
		unique case (ip_ff)
			IP_IDLE: begin
				if (byte_vld) begin
					unique case (byte_val)
						SET_POSITION_CMD: nxt_ip = IP_POS;
						UNDERLINE_OFF_CMD: nxt_ul = UL_OFF;
						UNDERLINE_ON_CMD: nxt_ul = UL_ON;
						UNDERLINE_BLINK_CMD: nxt_ul = UL_BLINK;
						DOT_MARKER_MODE_CMD: nxt_ip = IP_DOT;
						RESET_CMD: begin
							nxt_ip = IP_CLEAR;
							nxt_clr = 6'h00;
						end
						default: begin
							// other control codes are not handled here
							if (byte_val >= SPACE_CHAR) begin
								mem_we = 1'b1;
								nxt_pos = (pos_ff == POS_LAST) ?
									POS_HOME : pos_ff + 1'b1;
							end
						end
					endcase
				end
			end
			IP_POS: begin
				if (byte_vld) begin
					// any value is consumed; off-screen ones are dropped
					nxt_ip = IP_IDLE;
					if (byte_val <= POS_LAST_B)
						nxt_pos = byte_val[5:0];
				end
			end
			IP_DOT: begin
				if (byte_vld) begin
					nxt_ip = IP_IDLE;
					if (byte_val == DOT_LIGHT || byte_val == DOT_BLINK ||
						byte_val == DOT_NONE)
						nxt_dot = byte_val;
				end
			end
			IP_CLEAR: begin
				// one digit per clock; busy covers the whole sweep
				mem_we = 1'b1;
				mem_addr = clr_ff;
				mem_wd = SPACE_CHAR;
				nxt_busy = 1'b1;
				nxt_clr = clr_ff + 1'b1;
				nxt_ul = UL_BLINK;
				nxt_dot = DOT_NONE;
				nxt_pos = POS_HOME;
				if (clr_ff == POS_LAST)
					nxt_ip = IP_IDLE;
			end
		endcase
	end

	// power-on enters the same erase sweep as the reset command
	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			ip_ff <= IP_CLEAR;
			pos_ff <= POS_HOME;
			clr_ff <= 6'h00;
			ul_ff <= UL_BLINK;
			dot_ff <= DOT_NONE;
			busy_ff <= 1'b1;
			wait_ff <= 8'(BUSY_WAIT_CYC);
		end else begin
			ip_ff <= nxt_ip;
			pos_ff <= nxt_pos;
			clr_ff <= nxt_clr;
			ul_ff <= nxt_ul;
			dot_ff <= nxt_dot;
			busy_ff <= nxt_busy;
			wait_ff <= nxt_wait;
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (mem_we)
			mem[mem_addr] <= mem_wd;
	end
	assign LINK.busy = busy_ff;

	////////////////////////////////////////////////////////////////////////
	// blink timer, self-test sequence and display outputs
	logic [31:0] blk_ff, nxt_blk;
	logic        ph_ff, nxt_ph;
	logic [7:0]  tc_ff, nxt_tc;
	logic        occ;
	logic [7:0]  nxt_rd;
	logic        nxt_ul_show, nxt_dot_show, nxt_char_show;

	assign occ = (mem[pos_ff] != SPACE_CHAR);

	always_comb begin
		nxt_blk = blk_ff - 1'b1;
		nxt_ph = ph_ff;
		nxt_tc = tc_ff;
		if (blk_ff == 32'h0) begin
			nxt_blk = 32'(BLINK_CYCLES - 1);
			nxt_ph = !ph_ff;
			if (!LINK.test_n) begin
				// digits, then letters, then symbols
				unique case (tc_ff)
					ST_DIGIT_LAST: nxt_tc = ST_ALPHA_FIRST;
					ST_ALPHA_LAST: nxt_tc = ST_SYM_FIRST;
					ST_SYM_LAST: nxt_tc = ST_DIGIT_FIRST;
					default: nxt_tc = tc_ff + 1'b1;
				endcase
			end
		end
		if (LINK.test_n)
			nxt_tc = ST_DIGIT_FIRST;
		nxt_rd = (RD_ADDR <= POS_LAST) ? mem[RD_ADDR] : SPACE_CHAR;
		nxt_ul_show = (ul_ff == UL_ON) || (ul_ff == UL_BLINK && ph_ff);
		// marker always sits on the write position
		nxt_dot_show = (dot_ff == DOT_LIGHT) ||
			(dot_ff == DOT_BLINK && ph_ff);
		nxt_char_show = 1'b1;
		if (dot_ff == DOT_LIGHT && occ)
			nxt_char_show = 1'b0;
		else if (dot_ff == DOT_BLINK && occ)
			nxt_char_show = !ph_ff;
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			blk_ff <= 32'(BLINK_CYCLES - 1);
			ph_ff <= 1'b1;
			tc_ff <= ST_DIGIT_FIRST;
			RD_DATA <= SPACE_CHAR;
			POS <= POS_HOME;
			UL_SHOW <= 1'b0;
			DOT_SHOW <= 1'b0;
			CHAR_SHOW <= 1'b1;
			BRIGHT <= BRIGHT_FULL;
			SELFTEST <= 1'b0;
			TEST_CHAR <= ST_DIGIT_FIRST;
		end else begin
			blk_ff <= nxt_blk;
			ph_ff <= nxt_ph;
			tc_ff <= nxt_tc;
			RD_DATA <= nxt_rd;
			POS <= pos_ff;
			UL_SHOW <= nxt_ul_show;
			DOT_SHOW <= nxt_dot_show;
			CHAR_SHOW <= nxt_char_show;
			BRIGHT <= BRIGHT_FULL;
			SELFTEST <= !LINK.test_n;
			TEST_CHAR <= tc_ff;
		end
	end
endmodule

// [design/char_disp_host.sv]
`timescale 1ns/1ps
module char_disp_host
	import char_disp_pkg::*;
#(
	parameter int CLK_HZ = CLK_HZ_DEF
) (
	// clock and reset
	input  wire logic        REF_CLK,
	input  wire logic        RST,
	// avalon-mm slave
	input  wire logic [3:0]  ADDRESS,
	input  wire logic        READ,
	input  wire logic        WRITE,
	input  wire logic [31:0] WRITEDATA,
	output logic      [31:0] READDATA,
	output logic             WAITREQUEST,
	// link to display
	char_link_if.host        LINK
);
	initial begin
		// fastest rate needs two clocks a bit; slowest must fit the divider
		if (CLK_HZ < 125_000 || CLK_HZ > 300_000_000)
			$error("char_disp_host: CLK_HZ out of range");
	end

	typedef enum logic [4:0] {
		H_IDLE = 5'b00001, H_WAITB = 5'b00010, H_SER = 5'b00100,
		H_PW = 5'b01000, H_AFTER = 5'b10000
	} hst_t;

	hst_t             st_ff, nxt_st;
	logic [4:0]       ctrl_ff, nxt_ctrl;
	logic [7:0]       tx_ff, nxt_tx;
	logic [9:0]       frm_ff, nxt_frm;
	logic [3:0]       nb_ff, nxt_nb;
	logic [DIV_W-1:0] cnt_ff, nxt_cnt;
	logic             busy_ff;
	logic [31:0]      nxt_rdata;
	logic             nxt_waitreq, req, tx_hit, accept;
	logic [DIV_W-1:0] div;
	logic             ser;

	assign ser = ctrl_ff[CTRL_SERIAL_BIT];
	assign div = baud_div(ctrl_ff[CTRL_STRAP_LSB], ctrl_ff[CTRL_STRAP_LSB+1],
		ctrl_ff[CTRL_STRAP_LSB+2], CLK_HZ);
	assign req = READ || WRITE;
	assign tx_hit = WRITE && ADDRESS == REG_TXDATA;
	assign accept = req && !WAITREQUEST;

	////////////////////////////////////////////////////////////////////////
	// bus slave; a byte write stalls while the previous byte is in flight
	always_comb begin
		nxt_waitreq = 1'b1;
		nxt_rdata = READDATA;
		nxt_ctrl = ctrl_ff;
		if (req && WAITREQUEST && !(tx_hit && st_ff != H_IDLE)) begin
			nxt_waitreq = 1'b0;
			nxt_rdata = 32'h0;
			if (READ && ADDRESS == REG_CTRL)
				nxt_rdata = 32'(ctrl_ff);
			else if (READ && ADDRESS == REG_STATUS)
				nxt_rdata = 32'({busy_ff, st_ff != H_IDLE});
		end
		if (accept && WRITE && ADDRESS == REG_CTRL)
			nxt_ctrl = WRITEDATA[4:0];
	end

	////////////////////////////////////////////////////////////////////////
	// link engine
	always_comb begin
		nxt_st = st_ff;
		nxt_tx = tx_ff;
		nxt_frm = frm_ff;
		nxt_nb = nb_ff;
		nxt_cnt = cnt_ff;
		unique case (st_ff)
			H_IDLE: begin
				if (accept && tx_hit) begin
					nxt_tx = WRITEDATA[7:0];
					nxt_st = H_WAITB;
				end
			end
			H_WAITB: begin
				if (!busy_ff && ctrl_ff[CTRL_TEST_BIT]) begin
					nxt_st = H_IDLE; // self-test swallows the byte
				end else if (!busy_ff) begin
					nxt_st = ser ? H_SER : H_PW;
					nxt_frm = {1'b1, tx_ff, 1'b0};
					nxt_nb = 4'h0;
					nxt_cnt = ser ? div - 1'b1 : DIV_W'(WR_PW_CYC - 1);
				end
			end
			H_SER: begin
				if (cnt_ff != '0) begin
					nxt_cnt = cnt_ff - 1'b1;
				end else begin
					nxt_frm = {1'b1, frm_ff[9:1]};
					nxt_nb = nb_ff + 1'b1;
					nxt_cnt = div - 1'b1;
					if (nb_ff == 4'h9)
						nxt_st = H_IDLE;
				end
			end
			H_PW: begin
				if (cnt_ff != '0) begin
					nxt_cnt = cnt_ff - 1'b1;
				end else begin
					nxt_st = H_AFTER; // strobe rises here
					nxt_cnt = DIV_W'(WR_AFTER_CYC - 1);
				end
			end
			H_AFTER: begin
				// hold data past the strobe until busy must be up
				if (cnt_ff != '0)
					nxt_cnt = cnt_ff - 1'b1;
				else
					nxt_st = H_IDLE;
			end
		endcase
	end

	always_ff @(posedge REF_CLK) begin
		if (RST) begin
			st_ff <= H_IDLE;
			ctrl_ff <= CTRL_RESET;
			tx_ff <= 8'h00;
			frm_ff <= 10'h3ff;
			nb_ff <= 4'h0;
			cnt_ff <= '0;
			busy_ff <= 1'b1;
			READDATA <= 32'h0;
			WAITREQUEST <= 1'b1;
			LINK.test_n <= 1'b1;
			LINK.sel_n <= 1'b1;
			LINK.wr_n <= 1'b1;
			LINK.pdata <= 8'hff;
			LINK.rxd <= 1'b1;
			LINK.baud_strap_a <= 1'b1; // open by default
			LINK.baud_strap_b <= 1'b1;
			LINK.baud_strap_c <= 1'b1;
		end else begin
			st_ff <= nxt_st;
			ctrl_ff <= nxt_ctrl;
			tx_ff <= nxt_tx;
			frm_ff <= nxt_frm;
			nb_ff <= nxt_nb;
			cnt_ff <= nxt_cnt;
			busy_ff <= LINK.busy;
			READDATA <= nxt_rdata;
			WAITREQUEST <= nxt_waitreq;
			LINK.test_n <= !nxt_ctrl[CTRL_TEST_BIT];
			// unused lines idle high like open pins
			LINK.sel_n <= nxt_ctrl[CTRL_SERIAL_BIT] ||
				!(nxt_st == H_PW || nxt_st == H_AFTER);
			LINK.wr_n <= !(nxt_st == H_PW);
			LINK.pdata <= (nxt_st == H_PW || nxt_st == H_AFTER) ?
				nxt_frm[8:1] : 8'hff;
			LINK.rxd <= (nxt_st == H_SER) ? nxt_frm[0] : 1'b1;
			LINK.baud_strap_a <= nxt_ctrl[CTRL_STRAP_LSB];
			LINK.baud_strap_b <= nxt_ctrl[CTRL_STRAP_LSB+1];
			LINK.baud_strap_c <= nxt_ctrl[CTRL_STRAP_LSB+2];
		end
	end
endmodule

// [verif/char_disp_chk.sv]
`timescale 1ns/1ps
module char_disp_chk
	import char_disp_pkg::*;
(
	// clock and reset
	input wire logic       REF_CLK,
	input wire logic       RST,
	// link wires
	input wire logic       test_n,
	input wire logic       sel_n,
	input wire logic       wr_n,
	input wire logic [7:0] pdata,
	input wire logic       rxd,
	input wire logic       busy
);
	localparam int BUSY_MAX = 4500; // 45 us at 100 MHz
	localparam int BUSY_MIN = BUSY_WAIT_CYC; // 2 us at 100 MHz
	logic [12:0] busy_cnt_ff;
	logic [12:0] nxt_busy_cnt;

	// length of the busy stretch; saturates so a stuck busy never wraps
	always_comb begin
		nxt_busy_cnt = 13'h0;
		if (busy && busy_cnt_ff != 13'h1fff)
			nxt_busy_cnt = busy_cnt_ff + 13'h1;
		else if (busy)
			nxt_busy_cnt = busy_cnt_ff;
	end
	always_ff @(posedge REF_CLK) begin
		if (RST)
			busy_cnt_ff <= 13'h0;
		else
			busy_cnt_ff <= nxt_busy_cnt;
	end

	default clocking @(posedge REF_CLK);
	endclocking
	default disable iff (RST);

	////////////////////////////////////////////////////////////////////////
	a_take_busy: assert property (
		$rose(wr_n) && !sel_n && test_n && !busy |-> ##[1:3] busy)
		else $error("busy missing after parallel write");
	a_busy_min: assert property (
		$fell(busy) |-> busy_cnt_ff >= BUSY_MIN)
		else $error("busy wait too short");
	a_busy_max: assert property (
		busy_cnt_ff <= BUSY_MAX)
		else $error("busy wait too long");
	a_wait_busy: assert property (
		$fell(wr_n) |-> !busy)
		else $error("write strobe while busy");
	a_wr_width: assert property (
		$fell(wr_n) |-> !wr_n [*5] ##1 wr_n)
		else $error("write strobe width wrong");
	a_sel_hold: assert property (
		$rose(wr_n) |-> (!sel_n && $stable(pdata)) [*8])
		else $error("select or data not held");
	a_test_quiet: assert property (
		!test_n [*3] |-> !$rose(busy))
		else $error("byte taken during self-test");
	a_start_len: assert property (
		$fell(rxd) |-> !rxd [*8])
		else $error("serial low too short");
	a_par_idle: assert property (
		!sel_n |-> rxd)
		else $error("serial line active in parallel use");
	a_ser_idle: assert property (
		!rxd |-> sel_n && wr_n && pdata == 8'hff)
		else $error("parallel lines active in serial use");
endmodule

// [verif/tb_character_display_command_unit.sv]
`timescale 1ns/1ps
module tb_character_display_command_unit;
	import char_disp_pkg::*;
	localparam int HZ  = 2_000_000; // short bit periods keep the run small
	localparam int BLK = 20;
	logic        ref_clk;
	logic        rst;
	logic [3:0]  address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic        waitrequest;
	logic [5:0]  rd_addr;
	logic [7:0]  rd_data;
	logic [5:0]  pos;
	logic        ul_show;
	logic        dot_show;
	logic        char_show;
	logic [7:0]  bright;
	logic        selftest;
	logic [7:0]  test_char;
	logic        rxd;
	logic        busy;
	logic [2:0]  straps;
	int          n_fail;
	int          checked;

	char_link_if i_char_link_if ();
	assign rxd    = i_char_link_if.rxd;
	assign busy   = i_char_link_if.busy;
	assign straps = {i_char_link_if.baud_strap_c,
		i_char_link_if.baud_strap_b, i_char_link_if.baud_strap_a};

	char_disp_host #(.CLK_HZ(HZ)) i_char_disp_host (
		.REF_CLK(ref_clk), .RST(rst), .ADDRESS(address), .READ(read),
		.WRITE(write), .WRITEDATA(writedata), .READDATA(readdata),
		.WAITREQUEST(waitrequest), .LINK(i_char_link_if.host));
	char_disp_dev #(.CLK_HZ(HZ), .BLINK_CYCLES(BLK)) i_char_disp_dev (
		.REF_CLK(ref_clk), .RST(rst), .LINK(i_char_link_if.dev),
		.RD_ADDR(rd_addr), .RD_DATA(rd_data), .POS(pos),
		.UL_SHOW(ul_show), .DOT_SHOW(dot_show), .CHAR_SHOW(char_show),
		.BRIGHT(bright), .SELFTEST(selftest), .TEST_CHAR(test_char));
	char_disp_chk i_char_disp_chk (
		.REF_CLK(ref_clk), .RST(rst), .test_n(i_char_link_if.test_n),
		.sel_n(i_char_link_if.sel_n), .wr_n(i_char_link_if.wr_n),
		.pdata(i_char_link_if.pdata), .rxd(rxd), .busy(busy));

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// one avalon access, held until waitrequest is seen low at an edge
	task automatic av(input logic [3:0] a, input logic w,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		@(posedge ref_clk);
		address   <= a;
		write     <= w;
		read      <= !w;
		writedata <= d;
		n = 0;
		// waitrequest and read data are both taken at the same rising edge
		do begin
			@(posedge ref_clk);
			n++;
		end while (waitrequest !== 1'b0 && n < 60000);
		if (n >= 60000)
			n_fail++;
		q = readdata;
		write <= 1'b0;
		read  <= 1'b0;
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		logic [31:0] q;
		av(a, 1'b1, d, q);
	endtask
	// poll until engine and far end are both quiet
	task automatic idle();
		logic [31:0] q;
		int n;
		n = 0;
		do begin
			av(REG_STATUS, 1'b0, 32'h0, q);
			n++;
		end while (q[1:0] !== 2'b00 && n < 20000);
		if (q[1:0] !== 2'b00)
			n_fail++;
	endtask
	task automatic put(input logic [7:0] b);
		wr(REG_TXDATA, 32'(b));
		idle();
	endtask
	task automatic mem(input logic [5:0] a, output logic [7:0] v);
		@(posedge ref_clk);
		rd_addr <= a;
		@(posedge ref_clk);
		@(negedge ref_clk);
		v = rd_data;
	endtask
	// which levels each visibility output showed over a few blink phases
	task automatic watch(output logic [5:0] s);
		s = 6'h0;
		repeat (3 * BLK + 4) begin
			@(negedge ref_clk);
			s = s | {ul_show === 1'b1, ul_show === 1'b0, dot_show === 1'b1,
				dot_show === 1'b0, char_show === 1'b1, char_show === 1'b0};
		end
	endtask
	// state that power-on and the reset command must both leave
	task automatic fresh();
		logic [5:0] s;
		logic [7:0] v;
		chk(32'(pos), 32'h0);
		chk(32'(bright), 32'(BRIGHT_FULL));
		watch(s);
		chk(32'(s[5:2]), 32'hd);
		for (int i = 0; i < NUM_DIGITS; i++) begin
			mem(6'(i), v);
			chk(32'(v), 32'(SPACE_CHAR));
		end
	endtask
	// follow one frame on the wire from its falling start edge
	task automatic rx_mon(input int div, output logic [7:0] got,
		output int lo, output int tb_);
		int t;
		got = 8'h0;
		lo  = 0;
		tb_ = 0;
		t   = 0;
		while (rxd !== 1'b0 && t < 60000) begin
			@(negedge ref_clk);
			t++;
		end
		for (t = 1; t < 10 * div; t++) begin
			@(negedge ref_clk);
			if (rxd === 1'b1 && lo == 0)
				lo = t;
			if (busy === 1'b1 && tb_ == 0)
				tb_ = t;
			for (int i = 0; i < 8; i++)
				if (t == div / 2 + (i + 1) * div)
					got[i] = rxd;
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_par();
		logic [7:0] v;
		logic [7:0] ps [3] = '{8'h13, 8'h14, 8'h27};
		wr(REG_CTRL, 32'h1c);
		put(8'h41);
		put(8'h42);
		mem(6'h1, v);
		chk(32'(v), 32'h42);
		chk(32'(pos), 32'h2);
		for (int i = 0; i < 3; i++) begin
			put(SET_POSITION_CMD);
			put(ps[i]);
			chk(32'(pos), 32'(ps[i]));
		end
		put(8'h43);
		mem(6'h27, v);
		chk(32'(v), 32'h43);
		put(SET_POSITION_CMD);
		put(8'h30);
		chk(32'(pos), 32'h0);
		mem(6'h0, v);
		chk(32'(v), 32'h41);
	endtask
	task automatic t_cur();
		logic [5:0] s;
		logic [1:0] e [3] = '{2'b01, 2'b10, 2'b11};
		for (int i = 0; i < 3; i++) begin
			put(UNDERLINE_OFF_CMD + 8'(i));
			watch(s);
			chk(32'(s[5:4]), 32'(e[i]));
		end
	endtask
	// marker at an occupied cell: light, blink, none, then a bad mode
	task automatic t_dot();
		logic [5:0] s;
		logic [7:0] v;
		logic [7:0] m [3] = '{DOT_LIGHT, DOT_BLINK, DOT_NONE};
		logic [3:0] e [3] = '{4'b1001, 4'b1111, 4'b0110};
		for (int i = 0; i < 3; i++) begin
			put(DOT_MARKER_MODE_CMD);
			put(m[i]);
			watch(s);
			chk(32'(s[3:0]), 32'(e[i]));
		end
		put(DOT_MARKER_MODE_CMD);
		put(SET_POSITION_CMD);
		put(8'h44);
		chk(32'(pos), 32'h1);
		mem(6'h0, v);
		chk(32'(v), 32'h44);
		put(UNDERLINE_ON_CMD);
		put(DOT_MARKER_MODE_CMD);
		put(DOT_LIGHT);
		put(RESET_CMD);
		fresh();
	endtask
	task automatic t_test();
		logic [7:0] v;
		logic [7:0] e;
		int n;
		wr(REG_CTRL, 32'h1e);
		n = 0;
		while (selftest !== 1'b1 && n < 100) begin
			@(negedge ref_clk);
			n++;
		end
		// look at once: the first step may land on the very next edge
		chk(32'(test_char), 32'(ST_DIGIT_FIRST));
		for (int i = 1; i < 12; i++) begin
			v = test_char;
			n = 0;
			while (test_char === v && n < 4 * BLK) begin
				@(negedge ref_clk);
				n++;
			end
			e = (i < 10) ? ST_DIGIT_FIRST + 8'(i) : ST_ALPHA_FIRST + 8'(i - 10);
			chk(32'(test_char), 32'(e));
		end
		wr(REG_TXDATA, 32'h45);
		idle();
		wr(REG_CTRL, 32'h1c);
		idle();
		chk(32'(selftest), 32'h0);
		mem(6'h0, v);
		chk(32'(v), 32'(SPACE_CHAR));
	endtask
	// every strap code: bit period, bit order, busy moment, byte stored
	task automatic t_ser();
		int tt [8] = '{78125, 156250, 312500, 625000,
			12000, 24000, 48000, 96000};
		int div;
		int lo;
		int tb_;
		int mid;
		logic [7:0] b;
		logic [7:0] got;
		logic [7:0] v;
		for (int k = 0; k < 8; k++) begin
			div = int'((longint'(HZ) * 10 + tt[k] / 2) / tt[k]);
			mid = div * 9 + div / 2;
			b = 8'h41 + 8'(2 * k);
			wr(REG_CTRL, 32'(k * 4 + 1));
			fork
				put(b);
				rx_mon(div, got, lo, tb_);
			join
			chk(32'(straps), 32'(k));
			chk(32'(got), 32'(b));
			chk(32'(lo >= div - 1 && lo <= div + 1), 32'h1);
			chk(32'(tb_ >= mid - 2 && tb_ <= mid + 4), 32'h1);
			mem(6'(k), v);
			chk(32'(v), 32'(b));
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// watchdog: the whole sequence needs well under this span
	initial begin
		repeat (95000) @(posedge ref_clk);
		n_fail++;
		give_verdict();
	end
	initial begin
		logic [31:0] q;
		rst       = 1'b1;
		address   = 4'h0;
		read      = 1'b0;
		write     = 1'b0;
		writedata = 32'h0;
		rd_addr   = 6'h0;
		n_fail    = 0;
		checked   = 0;
		repeat (16) @(posedge ref_clk);
		chk(32'(straps), 32'h7);
		rst <= 1'b0;
		idle();
		chk(32'(straps), 32'h7);
		fresh();
		av(4'hc, 1'b0, 32'h0, q);
		chk(q, 32'h0);
		t_par();
		t_cur();
		t_dot();
		t_test();
		t_ser();
		give_verdict();
	end
endmodule
